// file: rtl/ip_bind_defs.svh
// register offsets, field positions, masks and reset values of the binding controls
// assumes 16-bit paged management registers, page already selected outside
`ifndef IP_BIND_DEFS_SVH
`define IP_BIND_DEFS_SVH

// ==========================================================
// register numbers within the page
`define V4_HOST_BIND_LO_IDX 6'h2A
`define V4_HOST_BIND_HI_IDX 6'h2B
`define V6_BIND_LO_IDX 6'h32
`define V6_BIND_HI_IDX 6'h33

// ==========================================================
// reset values and writable bits
`define V4_HOST_BIND_RESET 32'h0000_0000
`define V6_BIND_RESET 32'h0000_0000
`define V4_HOST_BIND_WMASK 32'hFFFF_D7FF
`define V6_BIND_WMASK 32'hBFFF_D7FF

// ==========================================================
// field positions, common to both registers except ARP at bit 30, which is reserved in the IPv6 register
`define BIND_TCP_LSB 0
`define BIND_TCP_MSB 10
`define BIND_UDP0_BIT 12
`define BIND_DHCP6_BIT 13
`define BIND_EAP_BIT 14
`define BIND_DNS_BIT 15
`define BIND_FLEX_LSB 16
`define BIND_FLEX_MSB 27
`define BIND_RANGE_BIT 28
`define BIND_ICMP_BIT 29
`define BIND_ARP_BIT 30
`define BIND_RMCP_BIT 31

// ==========================================================
// address table
`define V6_LOW24_ENTRIES 4
`define V6_LOW24_WIDTH 24

`endif

// file: rtl/ip_bind_pkg.sv
// types shared by the binding control and its port checker
// assumes ip_bind_defs.svh is on the include path
`include "ip_bind_defs.svh"

package ip_bind_pkg;

    // one bit per port filter: a hit going in, a pass coming out
    typedef struct packed {
        logic [10:0] tcp;
        logic udp0;
        logic dhcp6;
        logic eap;
        logic dns;
        logic [11:0] flex;
        logic range;
        logic icmp4;
        logic icmp6;
        logic arp;
        logic rmcp;
    } filter_bits_type;

    typedef struct packed {
        logic valid;
        logic is_ipv6;
        logic v4_host_match;
        logic [`V6_LOW24_WIDTH-1:0] v6_dst_low24;
        filter_bits_type hits;
    } packet_info_type;

    typedef enum logic [1:0] {
        MGMT_IDLE = 2'b00,
        MGMT_READ = 2'b01,
        MGMT_WRITE = 2'b10
    } mgmt_op_type;

endpackage

// file: rtl/v6_low24_address_filter.sv
// compares the low 24 bits of a packet's IPv6 address to the stored table
// assumes table entries and the packet address come from logic on clk
`timescale 1ns/1ps
`include "ip_bind_defs.svh"

module v6_low24_address_filter (
    input wire logic [`V6_LOW24_ENTRIES-1:0][`V6_LOW24_WIDTH-1:0] table_addr,
    input wire logic [`V6_LOW24_ENTRIES-1:0] table_valid,
    input wire logic [`V6_LOW24_WIDTH-1:0] pkt_low24,
    output logic match
);

    // ==========================================================
    // any valid entry hit
    always_comb begin
        match = 1'b0;
        for (int i = 0; i < `V6_LOW24_ENTRIES; i++) begin
            if (table_valid[i] && (table_addr[i] == pkt_low24)) begin
                match = 1'b1;
            end
        end
    end

endmodule

// file: rtl/ip_binding_filter_control.sv
// binding control registers and the gate they place on each port filter except dhcp6, whose bit 13 both write masks clear
// assumes paged management access with the page already decoded to mgmt_sel;
// filter hits and address matches arrive from logic on clk
`timescale 1ns/1ps
`include "ip_bind_defs.svh"

module ip_binding_filter_control (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic mgmt_sel,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [5:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_ack,
    input wire ip_bind_pkg::packet_info_type pkt_in,
    input wire logic [`V6_LOW24_ENTRIES-1:0][`V6_LOW24_WIDTH-1:0] v6_table_addr,
    input wire logic [`V6_LOW24_ENTRIES-1:0] v6_table_valid,
    output ip_bind_pkg::filter_bits_type pass_out,
    output logic pass_valid
);

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge_half(input logic [31:0] cur, input logic hi,
                                               input logic [15:0] wd, input logic [31:0] wmask);
        logic [31:0] upd;
        upd = hi ? {wd, cur[15:0]} : {cur[31:16], wd};
        merge_half = upd & wmask;
    endfunction

    // packet family selects which register applies; non-IPv6 (incl. ARP) uses IPv4
    function automatic logic gate(input logic hit, input logic b4, input logic b6,
                                  input logic is_v6, input logic m4, input logic m6);
        gate = hit & (is_v6 ? (~b6 | m6) : (~b4 | m4));
    endfunction

    // ==========================================================
    // registers and management access
    logic [31:0] v4_host_bind_reg, v4_host_bind_next;
    logic [31:0] v6_bind_reg, v6_bind_next;
    logic [15:0] rdata_reg, rdata_next;
    logic ack_reg, ack_next;
    ip_bind_pkg::mgmt_op_type op;

    always_comb begin
        op = ip_bind_pkg::MGMT_IDLE;
        if (mgmt_sel && mgmt_wr) begin
            op = ip_bind_pkg::MGMT_WRITE;
        end else if (mgmt_sel && mgmt_rd) begin
            op = ip_bind_pkg::MGMT_READ;
        end
    end

    always_comb begin
        v4_host_bind_next = v4_host_bind_reg;
        v6_bind_next = v6_bind_reg;
        rdata_next = rdata_reg;
        ack_next = 1'b0;
        case (op)
            ip_bind_pkg::MGMT_WRITE: begin
                ack_next = 1'b1;
                if (mgmt_addr == `V4_HOST_BIND_LO_IDX || mgmt_addr == `V4_HOST_BIND_HI_IDX) begin
                    v4_host_bind_next = merge_half(v4_host_bind_reg, mgmt_addr[0], mgmt_wdata,
                                                   `V4_HOST_BIND_WMASK);
                end
                // bit 13 held at zero by the mask
                if (mgmt_addr == `V6_BIND_LO_IDX || mgmt_addr == `V6_BIND_HI_IDX) begin
                    v6_bind_next = merge_half(v6_bind_reg, mgmt_addr[0], mgmt_wdata,
                                              `V6_BIND_WMASK);
                end
            end
            ip_bind_pkg::MGMT_READ: begin
                ack_next = 1'b1;
                case (mgmt_addr)
                    `V4_HOST_BIND_LO_IDX: rdata_next = v4_host_bind_reg[15:0];
                    `V4_HOST_BIND_HI_IDX: rdata_next = v4_host_bind_reg[31:16];
                    `V6_BIND_LO_IDX: rdata_next = v6_bind_reg[15:0];
                    `V6_BIND_HI_IDX: rdata_next = v6_bind_reg[31:16];
                    default: rdata_next = 16'h0000;
                endcase
            end
            default: begin
                ack_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            v4_host_bind_reg <= `V4_HOST_BIND_RESET;
            v6_bind_reg <= `V6_BIND_RESET;
            rdata_reg <= 16'h0000;
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            v4_host_bind_reg <= v4_host_bind_next;
            v6_bind_reg <= v6_bind_next;
            rdata_reg <= rdata_next;
            ack_reg <= ack_next;
        end
    end

    assign mgmt_rdata = rdata_reg;
    assign mgmt_ack = ack_reg;

    // ==========================================================
    // address match and gating
    logic v6_match;

    v6_low24_address_filter u_v6_low24 (
        .table_addr(v6_table_addr),
        .table_valid(v6_table_valid),
        .pkt_low24(pkt_in.v6_dst_low24),
        .match(v6_match)
    );

    ip_bind_pkg::filter_bits_type pass_reg, pass_next;
    logic pass_valid_reg, pass_valid_next;
    logic is6, m4;
    logic [31:0] b4, b6;

    always_comb begin
        is6 = pkt_in.is_ipv6;
        m4 = pkt_in.v4_host_match;
        b4 = v4_host_bind_reg;
        b6 = v6_bind_reg;
        pass_next = '0;
        pass_valid_next = pkt_in.valid;
        for (int i = 0; i <= `BIND_TCP_MSB; i++) begin
            pass_next.tcp[i] = gate(pkt_in.hits.tcp[i], b4[`BIND_TCP_LSB + i],
                                    b6[`BIND_TCP_LSB + i], is6, m4, v6_match);
        end
        pass_next.udp0 = gate(pkt_in.hits.udp0, b4[`BIND_UDP0_BIT], b6[`BIND_UDP0_BIT],
                              is6, m4, v6_match);
        pass_next.dhcp6 = gate(pkt_in.hits.dhcp6, 1'b0, b6[`BIND_DHCP6_BIT], is6, m4, v6_match);
        // eap over udp and name service
        pass_next.eap = gate(pkt_in.hits.eap, b4[`BIND_EAP_BIT], b6[`BIND_EAP_BIT],
                             is6, m4, v6_match);
        pass_next.dns = gate(pkt_in.hits.dns, b4[`BIND_DNS_BIT], b6[`BIND_DNS_BIT],
                             is6, m4, v6_match);
        for (int i = 0; i <= `BIND_FLEX_MSB - `BIND_FLEX_LSB; i++) begin
            pass_next.flex[i] = gate(pkt_in.hits.flex[i], b4[`BIND_FLEX_LSB + i],
                                     b6[`BIND_FLEX_LSB + i], is6, m4, v6_match);
        end
        pass_next.range = gate(pkt_in.hits.range, b4[`BIND_RANGE_BIT], b6[`BIND_RANGE_BIT],
                               is6, m4, v6_match);
        pass_next.icmp4 = gate(pkt_in.hits.icmp4, b4[`BIND_ICMP_BIT], 1'b0, is6, m4, v6_match);
        pass_next.icmp6 = gate(pkt_in.hits.icmp6, 1'b0, b6[`BIND_ICMP_BIT], is6, m4, v6_match);
        pass_next.arp = gate(pkt_in.hits.arp, b4[`BIND_ARP_BIT], 1'b0, 1'b0, m4, v6_match);
        pass_next.rmcp = gate(pkt_in.hits.rmcp, b4[`BIND_RMCP_BIT], b6[`BIND_RMCP_BIT],
                              is6, m4, v6_match);
        if (!pkt_in.valid) begin
            pass_next = '0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pass_reg <= '0;
            pass_valid_reg <= 1'b0;
        end else if (clk_en) begin
            pass_reg <= pass_next;
            pass_valid_reg <= pass_valid_next;
        end
    end

    assign pass_out = pass_reg;
    assign pass_valid = pass_valid_reg;

endmodule

// file: sim/bind_checker_sva.sv
// port checker for the binding control
// assumes it is bound to the top module from the bench top file
`timescale 1ns/1ps
module bind_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic mgmt_sel,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [5:0] mgmt_addr,
    input wire logic [15:0] mgmt_rdata,
    input wire logic mgmt_ack,
    input wire ip_bind_pkg::packet_info_type pkt_in,
    input wire ip_bind_pkg::filter_bits_type pass_out,
    input wire logic pass_valid
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // register access
    logic rd_t;
    logic req_t;
    assign rd_t = clk_en && mgmt_sel && mgmt_rd && !mgmt_wr;
    assign req_t = clk_en && mgmt_sel && (mgmt_wr || mgmt_rd);
    ack_after_a: assert property (req_t |=> mgmt_ack) else $error("ack missing");
    ack_pulse_a: assert property (clk_en && !req_t |=> !mgmt_ack) else $error("stray ack");
    rsvd_low_a: assert property (rd_t && !mgmt_addr[0] |=> (mgmt_rdata & 16'h2800) == 16'h0000)
        else $error("reserved low bits set");
    rsvd_v6hi_a: assert property (rd_t && mgmt_addr == 6'h33 |=> !mgmt_rdata[14])
        else $error("reserved bit 30 set");
    unmapped_a: assert property (rd_t && !(mgmt_addr inside {6'h2A, 6'h2B, 6'h32, 6'h33})
        |=> mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
    // ==========================================================
    // packet path
    pass_valid_a: assert property (clk_en |=> pass_valid == $past(pkt_in.valid))
        else $error("pass valid wrong");
    pass_hit_a: assert property (clk_en |=> (pass_out & ~$past(pkt_in.hits)) == 32'h0)
        else $error("pass without hit");
    invalid_zero_a: assert property (clk_en && !pkt_in.valid |=> pass_out == 32'h0)
        else $error("pass on invalid packet");
    v4_match_a: assert property (clk_en && pkt_in.valid && !pkt_in.is_ipv6 && pkt_in.v4_host_match
        |=> pass_out == $past(pkt_in.hits)) else $error("matched packet gated");
    hold_a: assert property (!clk_en |=> $stable(pass_out) && $stable(mgmt_ack))
        else $error("state moved while disabled");
endmodule

// file: sim/ip_binding_filter_control_test.sv
// self-checking bench for the binding control
// assumes the rtl header and package are compiled first
`timescale 1ns/1ps
`include "ip_bind_defs.svh"
module ip_binding_filter_control_test;
    // ==========================================================
    // stimulus and helpers
    localparam logic [31:0] HITS4 = 32'hFFF7_FFFB;
    localparam logic [31:0] HITS6 = 32'hFFFF_FFF5;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic mgmt_sel = 1'b0;
    logic mgmt_wr = 1'b0;
    logic mgmt_rd = 1'b0;
    logic [5:0] mgmt_addr = 6'h00;
    logic [15:0] mgmt_wdata = 16'h0000;
    logic [15:0] mgmt_rdata;
    logic mgmt_ack;
    ip_bind_pkg::packet_info_type pkt_in = '0;
    logic [3:0][23:0] tbl = {24'h0, 24'h0, 24'h123456, 24'h5A5A5A};
    logic [3:0] tvld = 4'h1;
    ip_bind_pkg::filter_bits_type pass_out;
    logic pass_valid;
    int fail_count = 0;
    int n_checks = 0;
    ip_binding_filter_control u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .mgmt_sel(mgmt_sel), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack), .pkt_in(pkt_in),
        .v6_table_addr(tbl), .v6_table_valid(tvld), .pass_out(pass_out),
        .pass_valid(pass_valid));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d);
        mgmt_sel = 1'b1;
        mgmt_wr = wr;
        mgmt_rd = !wr;
        mgmt_addr = a;
        mgmt_wdata = d;
        @(negedge clk);
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        check("ack", 32'h1, {31'h0, mgmt_ack});
    endtask
    task automatic wr32(input logic [5:0] a, input logic [31:0] v);
        access(1'b1, a, v[15:0]);
        access(1'b1, a + 6'h1, v[31:16]);
    endtask
    task automatic rd32(input logic [5:0] a, input logic [31:0] e);
        access(1'b0, a, 16'h0000);
        check("rdata low", {16'h0, e[15:0]}, {16'h0, mgmt_rdata});
        access(1'b0, a + 6'h1, 16'h0000);
        check("rdata high", {16'h0, e[31:16]}, {16'h0, mgmt_rdata});
    endtask
    task automatic pkt(input logic v6, input logic m4, input logic [23:0] a,
        input logic [31:0] h, input logic [31:0] e);
        pkt_in = {1'b1, v6, m4, a, h};
        @(negedge clk);
        pkt_in.valid = 1'b0;
        check("pass_valid", 32'h1, {31'h0, pass_valid});
        check("pass_out", e, pass_out);
    endtask
    // field order of the pass struct, one enable bit per field
    function automatic logic [31:0] gated(input logic [31:0] r);
        return {r[10:0], r[12], r[13], r[14], r[15], r[27:16], r[28], r[29], r[29], r[30], r[31]};
    endfunction
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rd32(6'h2A, 32'h0);
        rd32(6'h32, 32'h0);
    endtask
    task automatic t_unmapped();
        access(1'b1, 6'h10, 16'hFFFF);
        access(1'b0, 6'h10, 16'h0000);
        check("unmapped", 32'h0, {16'h0, mgmt_rdata});
    endtask
    task automatic t_v4_bits();
        logic [31:0] e;
        for (int i = 0; i < 32; i++) begin
            e = (32'h1 << i) & `V4_HOST_BIND_WMASK;
            wr32(6'h2A, 32'h1 << i);
            rd32(6'h2A, e);
            pkt(1'b0, 1'b0, 24'h0, HITS4, HITS4 & ~gated(e));
            pkt(1'b0, 1'b1, 24'h0, HITS4, HITS4);
        end
    endtask
    // ipv4 enables all set, must not touch ipv6 packets except the arp hit, which HITS6 leaves clear
    task automatic t_v6_bits();
        logic [31:0] e;
        wr32(6'h2A, 32'hFFFF_FFFF);
        for (int i = 0; i < 32; i++) begin
            e = (32'h1 << i) & `V6_BIND_WMASK;
            wr32(6'h32, 32'h1 << i);
            rd32(6'h32, e);
            pkt(1'b1, 1'b0, 24'h5A5A5A, HITS6, HITS6);
            pkt(1'b1, 1'b1, 24'h123456, HITS6, HITS6 & ~gated(e));
            pkt(1'b1, 1'b0, 24'h5A5A5B, HITS6, HITS6 & ~gated(e));
        end
    endtask
    task automatic t_stall();
        // write offered while frozen must neither ack nor land
        clk_en = 1'b0;
        mgmt_sel = 1'b1;
        mgmt_wr = 1'b1;
        mgmt_addr = 6'h2A;
        mgmt_wdata = 16'h0000;
        @(negedge clk);
        check("stalled ack", 32'h0, {31'h0, mgmt_ack});
        mgmt_wr = 1'b0;
        clk_en = 1'b1;
        @(negedge clk);
        check("frozen ack", 32'h0, {31'h0, mgmt_ack});
        rd32(6'h2A, `V4_HOST_BIND_WMASK);
    endtask
    task automatic t_rerst();
        sys_rst = 1'b1;
        @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        results();
    end
    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        t_reset();
        t_unmapped();
        t_v4_bits();
        t_v6_bits();
        t_stall();
        t_rerst();
        results();
    end
endmodule
bind ip_binding_filter_control bind_checker u_chk (.clk(clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .mgmt_sel(mgmt_sel), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_addr(mgmt_addr), .mgmt_rdata(mgmt_rdata), .mgmt_ack(mgmt_ack), .pkt_in(pkt_in),
    .pass_out(pass_out), .pass_valid(pass_valid));
